// >>> hdl/cpei_event_irq.sv
// event flags, real-time tick and autonomous periodic timer with wishbone registers
//
// Operation
// RULE1 - tick counter steps on internal rc or crystal clock per select bit
// RULE2 - in stop, tick runs only if pseudo stop, crystal and keep-run set
// RULE3 - tick period end sets tick flag, restarts, requests when enabled
// RULE4 - any write to tick rate register restarts the tick period
// RULE5 - pll lock toggle sets lock flag; only writing one clears it
// RULE6 - lock request is suppressed while lock enable is zero
// RULE7 - osc good held zero while osc off; set only after pll lock
// RULE8 - every change of osc good sets the crystal status flag
// RULE9 - losing pll lock also clears osc good
// RULE10 - crystal status request only while its enable is set
// RULE11 - in full performance, low-voltage status follows detector levels
// RULE12 - each low-voltage status change sets its flag; request if enabled
// RULE13 - in full performance, over-temp status follows sensor levels
// RULE14 - each over-temp status change sets its flag; request if enabled
// RULE15 - periodic timer runs on rc or bus clock; frozen if bus clock off
// RULE16 - period and clock select writes ignored while periodic timer enabled
// RULE17 - periodic timer starts counting the period once enabled
// RULE18 - period elapsed sets periodic flag, restarts, requests when enabled
// RULE19 - software disables timer before changing period or clock select
// RULE20 - output pin toggles when periodic enable and pin enable are set
// RULE21 - first period may be shorter by the start-up delay
// RULE22 - flags clear only on write one; write zero leaves them
// RULE23 - each request is flag and enable, held until either drops
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps

`include "cpei_defines.svh"

module cpei_event_irq #(
  parameter int RATE_W = 16                        // tick rate width
) (
  input  wire logic                  clk_sys,      // 125 mhz system clock
  input  wire logic                  reset_n,      // async reset, active low
  input  wire cpei_pkg::cpei_wb_req_t wbReq,       // wishbone request
  output logic [31:0]                wbDatO,       // wishbone read data
  output logic                       wbAck,        // wishbone acknowledge
  input  wire logic                  internalRcClk, // internal rc clock, async
  input  wire logic                  crystalClk,   // crystal clock, async
  input  wire logic                  autoRcClk,    // autonomous rc clock, async
  input  wire logic                  busClkOn,     // bus clock running, same domain
  input  wire logic                  stopMode,     // stop mode active, same domain
  input  wire logic                  fullPerfMode, // full performance mode, same domain
  input  wire logic                  pllLock,      // pll lock status, async
  input  wire logic                  lowSupplyDet, // low voltage detector, async
  input  wire logic                  overTempDet,  // over temperature sensor, async
  output cpei_pkg::cpei_evt_t        irqReq,       // per-source interrupt requests
  output logic                       periodicTimerOutputPin, // periodic waveform
  output logic                       crystalOscGood // oscillator good status
);

  cpei_pkg::cpei_state_t st_r;
  cpei_pkg::cpei_state_t st_nxt;

  logic                  acc;
  logic                  wr;
  logic [31:0]           wdat;
  logic [5:0]            flagW;
  logic [3:0]            clkEdge;
  logic                  tickStep;
  logic                  perStep;
  logic                  lockNow;
  logic                  lvNow;
  logic                  htNow;
  logic                  oscGoodNxt;
  cpei_pkg::cpei_evt_t   setEv;

  // decode and edge detection helpers
  always_comb begin
    acc     = wbReq.cyc & wbReq.stb & ~st_r.ack;
    wr      = acc & wbReq.we;
    wdat    = wbReq.dat;
    flagW   = wdat[5:0];
    // edges only from second sync stage, never the first
    clkEdge = st_r.edgeSync2 & ~st_r.edgeLast;
    lockNow = st_r.sync2[0];
    lvNow   = st_r.sync2[1];
    htNow   = st_r.sync2[2];
    // RULE1 tick source select
    tickStep = st_r.tickCsel ? clkEdge[1] : clkEdge[0];
    // RULE2 stop mode hold
    if (stopMode && !(st_r.pstop && st_r.tickCsel && st_r.keepRun)) begin
      tickStep = 1'b0;
    end
    // RULE15 periodic source, frozen without bus clock when the bus clock is selected
    perStep = st_r.perCsel ? busClkOn : clkEdge[2];
  end

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    setEv  = '0;

    // two flip-flop synchronisers for async levels and clocks
    st_nxt.sync1     = {2'b00, overTempDet, lowSupplyDet, pllLock};
    st_nxt.sync2     = st_r.sync1;
    st_nxt.edgeSync1 = {1'b0, autoRcClk, crystalClk, internalRcClk};
    st_nxt.edgeSync2 = st_r.edgeSync1;
    st_nxt.edgeLast  = st_r.edgeSync2;

    // RULE3 tick period end
    if (tickStep) begin
      if (st_r.tickCnt >= st_r.tickRate) begin
        st_nxt.tickCnt = 16'h0000;
        setEv.tick     = 1'b1;
      end else begin
        st_nxt.tickCnt = st_r.tickCnt + 16'h0001;
      end
    end

    // RULE5 lock toggle detection
    st_nxt.lockPrev = lockNow;
    if (lockNow != st_r.lockPrev) begin
      setEv.lock = 1'b1;
    end

    // RULE7 RULE9 osc good qualified by enable and lock
    oscGoodNxt = st_r.oscEn & lockNow & (st_r.oscGood | st_r.lockPrev);
    st_nxt.oscGood = oscGoodNxt;
    // RULE8 any osc good change flags
    if (oscGoodNxt != st_r.oscGood) begin
      setEv.osc = 1'b1;
    end

    // RULE11 RULE13 status follows detectors in full performance only
    if (fullPerfMode) begin
      st_nxt.lvStatus = lvNow;
      st_nxt.htStatus = htNow;
    end
    // RULE12 low voltage change
    if (st_nxt.lvStatus != st_r.lvStatus) begin
      setEv.lvolt = 1'b1;
    end
    // RULE14 over temp change
    if (st_nxt.htStatus != st_r.htStatus) begin
      setEv.htemp = 1'b1;
    end

    // RULE17 RULE21 counts from enable; start delay preloads the count
    if (!st_r.perEn) begin
      st_nxt.perCnt  = 17'(`CPEI_START_DELAY);
      st_nxt.perWave = 1'b0;
    end else if (perStep) begin
      // RULE18 period elapsed, auto restart
      if (st_r.perCnt >= {1'b0, st_r.perPeriod}) begin
        st_nxt.perCnt  = 17'h00000;
        st_nxt.perWave = ~st_r.perWave;
        setEv.per      = 1'b1;
      end else begin
        st_nxt.perCnt = st_r.perCnt + 17'h00001;
      end
    end

    // wishbone ack and read data
    st_nxt.ack = acc;
    if (acc && !wbReq.we) begin
      unique case (wbReq.adr)
        `CPEI_OFS_FLAGS:    st_nxt.rdData = {26'h0, st_r.flags};
        `CPEI_OFS_ENABLES:  st_nxt.rdData = {26'h0, st_r.enables};
        `CPEI_OFS_TICKRATE: st_nxt.rdData = {16'h0, st_r.tickRate};
        `CPEI_OFS_PERCTL:   st_nxt.rdData = {29'h0, st_r.perPinEn, st_r.perCsel, st_r.perEn};
        `CPEI_OFS_PERIOD:   st_nxt.rdData = {16'h0, st_r.perPeriod};
        `CPEI_OFS_STATUS:   st_nxt.rdData = {28'h0, st_r.htStatus, st_r.lvStatus,
                                             st_r.oscGood, lockNow};
        `CPEI_OFS_CLKCTL:   st_nxt.rdData = {28'h0, st_r.oscEn, st_r.keepRun,
                                             st_r.pstop, st_r.tickCsel};
        default:            st_nxt.rdData = 32'h0000_0000; // unmapped reads zero
      endcase
    end

    // RULE22 write one clears; set wins over clear below
    if (wr && wbReq.adr == `CPEI_OFS_FLAGS && wbReq.sel[0]) begin
      st_nxt.flags = st_r.flags & ~cpei_pkg::cpei_evt_t'(flagW);
    end
    st_nxt.flags = st_nxt.flags | setEv;

    if (wr && wbReq.sel[0]) begin
      unique case (wbReq.adr)
        `CPEI_OFS_ENABLES: st_nxt.enables = cpei_pkg::cpei_evt_t'(flagW);
        `CPEI_OFS_CLKCTL: begin
          st_nxt.tickCsel = wdat[`CPEI_BIT_TICK_CSEL];
          st_nxt.pstop    = wdat[`CPEI_BIT_PSTOP];
          st_nxt.keepRun  = wdat[`CPEI_BIT_KEEPRUN];
          st_nxt.oscEn    = wdat[`CPEI_BIT_OSC_EN];
        end
        `CPEI_OFS_PERCTL: begin
          st_nxt.perEn    = wdat[`CPEI_BIT_PER_EN];
          st_nxt.perPinEn = wdat[`CPEI_BIT_PER_PIN];
          // RULE16 clock select locked while enabled
          if (!st_r.perEn) begin
            st_nxt.perCsel = wdat[`CPEI_BIT_PER_CSEL];
          end
        end
        default: begin
        end
      endcase
    end

    // RULE4 tick rate write restarts the period
    if (wr && wbReq.adr == `CPEI_OFS_TICKRATE) begin
      if (wbReq.sel[0]) st_nxt.tickRate[7:0] = wdat[7:0];
      if (wbReq.sel[1]) st_nxt.tickRate[15:8] = wdat[15:8];
      st_nxt.tickCnt = 16'h0000;
    end

    // RULE16 RULE19 period writable only while disabled
    if (wr && wbReq.adr == `CPEI_OFS_PERIOD && !st_r.perEn) begin
      if (wbReq.sel[0]) st_nxt.perPeriod[7:0] = wdat[7:0];
      if (wbReq.sel[1]) st_nxt.perPeriod[15:8] = wdat[15:8];
    end

    // RULE20 wave held low unless both enables, so the pin leaves a flop
    if (!(st_nxt.perEn && st_nxt.perPinEn)) begin
      st_nxt.perWave = 1'b0;
    end

    // RULE6 RULE10 RULE23 request is flag and enable
    st_nxt.irq = st_nxt.flags & st_nxt.enables;
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r           <= '0;
      st_r.tickRate  <= `CPEI_RST_TICKRATE;
      st_r.perPeriod <= `CPEI_RST_PERIOD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign wbDatO                 = st_r.rdData;
  assign wbAck                  = st_r.ack;
  assign irqReq                 = st_r.irq;
  // RULE20 pin driven only with both enables
  assign periodicTimerOutputPin = st_r.perWave;
  assign crystalOscGood         = st_r.oscGood;

endmodule

// >>> hdl/cpei_defines.svh
// register offsets, field positions, reset values and timing counts of the event block
`ifndef CPEI_DEFINES_SVH
`define CPEI_DEFINES_SVH

// byte offsets on the wishbone bus (one aligned word each)
`define CPEI_OFS_FLAGS     8'h00
`define CPEI_OFS_ENABLES   8'h04
`define CPEI_OFS_TICKRATE  8'h08
`define CPEI_OFS_PERCTL    8'h0c
`define CPEI_OFS_PERIOD    8'h10
`define CPEI_OFS_STATUS    8'h14
`define CPEI_OFS_CLKCTL    8'h18

// flag / enable bit positions (same layout in both registers)
`define CPEI_BIT_TICK      0
`define CPEI_BIT_LOCK      1
`define CPEI_BIT_OSC       2
`define CPEI_BIT_LVOLT     3
`define CPEI_BIT_HTEMP     4
`define CPEI_BIT_PER       5

// periodic control register bits
`define CPEI_BIT_PER_EN    0
`define CPEI_BIT_PER_CSEL  1
`define CPEI_BIT_PER_PIN   2

// clock control register bits
`define CPEI_BIT_TICK_CSEL 0
`define CPEI_BIT_PSTOP     1
`define CPEI_BIT_KEEPRUN   2
`define CPEI_BIT_OSC_EN    3

// reset values
`define CPEI_RST_TICKRATE  16'h00ff
`define CPEI_RST_PERIOD    16'h0000

// periodic timer start-up delay, in cycles of the selected source
`define CPEI_START_DELAY   2

`endif

// >>> hdl/cpei_pkg.sv
// types shared by the clock power event block
package cpei_pkg;

  // one wishbone classic request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cpei_wb_req_t;

  // six event flags, also used for enables and requests
  typedef struct packed {
    logic per;
    logic htemp;
    logic lvolt;
    logic osc;
    logic lock;
    logic tick;
  } cpei_evt_t;

  // whole state of the block
  typedef struct packed {
    cpei_evt_t   flags;
    cpei_evt_t   enables;
    cpei_evt_t   irq;
    logic [15:0] tickRate;
    logic [15:0] tickCnt;
    logic        tickCsel;
    logic        pstop;
    logic        keepRun;
    logic        oscEn;
    logic        perEn;
    logic        perCsel;
    logic        perPinEn;
    logic [15:0] perPeriod;
    logic [16:0] perCnt;
    logic        perWave;
    logic        lockPrev;
    logic        oscGood;
    logic        lvStatus;
    logic        htStatus;
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [3:0]  edgeSync1;
    logic [3:0]  edgeSync2;
    logic [3:0]  edgeLast;
    logic        ack;
    logic [31:0] rdData;
  } cpei_state_t;

endpackage

// >>> verif/cpei_event_irq_asserts.sv
// port checks for the clock power event block
`timescale 1ns/100ps
module cpei_event_irq_asserts (
  input wire logic                   clk_sys,       // system clock
  input wire logic                   reset_n,       // async reset, active low
  input wire cpei_pkg::cpei_wb_req_t wbReq,         // bus request
  input wire logic                   wbAck,         // bus ack
  input wire logic                   pllLock,       // lock input
  input wire logic                   lowSupplyDet,  // voltage detector
  input wire logic                   overTempDet,   // temperature sensor
  input wire cpei_pkg::cpei_evt_t    irqReq,        // requests
  input wire logic                   crystalOscGood // osc good
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // bus answers one cycle after the take, for one cycle
  a_ack_answer: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
    else $error("request not acked");
  a_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack too long");
  // requests only drop after a register access
  a_irq_drop_write: assert property (|($past(irqReq) & ~irqReq) |->
    wbAck || $past(wbAck))
    else $error("request dropped alone");
  // a new lock, low voltage or over temp request needs an input change or an enable write
  a_lock_cause: assert property ($rose(irqReq.lock) |->
    wbAck || $past(pllLock, 2) != $past(pllLock, 7))
    else $error("lock request without cause");
  a_lv_cause: assert property ($rose(irqReq.lvolt) |->
    wbAck || $past(lowSupplyDet, 2) != $past(lowSupplyDet, 7))
    else $error("low supply request without cause");
  a_ht_cause: assert property ($rose(irqReq.htemp) |->
    wbAck || $past(overTempDet, 2) != $past(overTempDet, 7))
    else $error("over temp request without cause");
  // osc good never outlives the lock and never comes before it
  a_osc_lost: assert property (!pllLock [*8] |-> !crystalOscGood)
    else $error("osc good kept without lock");
  a_osc_rise: assert property ($rose(crystalOscGood) |-> $past(pllLock, 2))
    else $error("osc good rose without lock");
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the clock power event block
`timescale 1ns/100ps
module tb_top;
  logic                   clk_sys, reset_n, wbAck, pin, oscGood, busClkOn, stopMode;
  logic                   internalRcClk, crystalClk, autoRcClk, fullPerfMode, pllLock;
  logic                   lowSupplyDet, overTempDet;
  logic [31:0]            wbDatO, rnd, expQ[$];
  logic [7:0]             div;
  cpei_pkg::cpei_wb_req_t wbReq;
  cpei_pkg::cpei_evt_t    irqReq;
  int                     errTotal, nChecks, seed, n;
  cpei_event_irq u_dut (.clk_sys, .reset_n, .wbReq, .wbDatO, .wbAck, .internalRcClk,
    .crystalClk, .autoRcClk, .busClkOn, .stopMode, .fullPerfMode, .pllLock, .lowSupplyDet,
    .overTempDet, .irqReq, .periodicTimerOutputPin(pin), .crystalOscGood(oscGood));
  // bench clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // slow sources from a divider: rc 8, auto rc 16, crystal 32 cycles
  always @(posedge clk_sys) begin
    div <= div + 8'h01;
    {crystalClk, autoRcClk, internalRcClk} <= {div[4], div[3], div[2]};
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e) begin
      errTotal++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic endSim;
    if (errTotal == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  // one classic cycle: held until ack is sampled, then idle a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wbReq <= '{1'b1, 1'b1, w, a, 4'hf, d};
    @(posedge clk_sys);
    while (wbAck !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 20) chk(32'h0, 32'h1);
    wbReq <= '0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  // expected data is noted before the read goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic toggles(input int c, output int t);
    logic last;
    t = 0;
    last = pin;
    repeat (c) begin
      @(posedge clk_sys);
      t += int'(pin !== last);
      last = pin;
    end
  endtask
  // read data against the oldest note
  always @(posedge clk_sys)
    if (wbAck === 1'b1 && wbReq.we === 1'b0 && expQ.size() > 0) chk(wbDatO, expQ.pop_front());
  // hang guard, far beyond the thousand or so cycles used
  initial begin
    wt(20000);
    chk(32'h0, 32'h1);
    endSim();
  end
  initial begin
    {reset_n, busClkOn, stopMode, pllLock, lowSupplyDet, overTempDet} = '0;
    {div, wbReq} = '0;
    fullPerfMode = 1'b1;
    seed = 81;
    errTotal = 0;
    nChecks = 0;
    wt(3);
    reset_n <= 1'b1;
    // reset values, unmapped read, random rate kept
    rd(8'h08, 32'h00ff);
    rd(8'h1c, 32'h0);
    rnd = $random(seed) & 32'hffff;
    wr(8'h08, rnd);
    rd(8'h08, rnd);
    // rate rewrites keep restarting the rc tick period
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h3f);
    repeat (4) begin
      wt(12);
      wr(8'h08, 32'h3);
    end
    rd(8'h00, 32'h0);
    wt(40);
    rd(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    wt(2);
    chk(32'(irqReq), 32'h1);
    // stop halts the tick unless pseudo stop on crystal keeps it
    stopMode <= 1'b1;
    wr(8'h00, 32'h1);
    wt(100);
    rd(8'h00, 32'h0);
    wr(8'h18, 32'h7);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h1);
    wt(60);
    rd(8'h00, 32'h0);
    wt(110);
    rd(8'h00, 32'h1);
    stopMode <= 1'b0;
    wr(8'h08, 32'hffff);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h3f);
    // lock toggle: flag set, masked, cleared by a one only
    pllLock <= 1'b1;
    wt(8);
    rd(8'h00, 32'h2);
    chk(32'(irqReq), 32'h0);
    chk(32'(oscGood), 32'h0);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h2);
    wr(8'h04, 32'h3f);
    wt(2);
    chk(32'(irqReq), 32'h2);
    wr(8'h00, 32'h2);
    wt(2);
    chk(32'(irqReq), 32'h0);
    // osc good follows the enable and the lock
    wr(8'h18, 32'h8);
    wt(6);
    chk(32'(oscGood), 32'h1);
    chk(32'(irqReq), 32'h4);
    wr(8'h00, 32'h3f);
    pllLock <= 1'b0;
    wt(8);
    chk(32'(oscGood), 32'h0);
    rd(8'h00, 32'h6);
    wr(8'h04, 32'h3b);
    wt(2);
    chk(32'(irqReq), 32'h2);
    // detectors reach status only in full performance
    wr(8'h00, 32'h3f);
    {lowSupplyDet, overTempDet} <= 2'b11;
    wt(8);
    rd(8'h14, 32'hc);
    rd(8'h00, 32'h18);
    chk(32'(irqReq), 32'h18);
    fullPerfMode <= 1'b0;
    lowSupplyDet <= 1'b0;
    wt(8);
    rd(8'h14, 32'hc);
    // periodic timer on the bus clock, setup locked while running
    busClkOn <= 1'b1;
    wr(8'h10, 32'h7);
    wr(8'h0c, 32'h7);
    wr(8'h10, rnd | 32'h100);
    wr(8'h0c, 32'h5);
    rd(8'h10, 32'h7);
    rd(8'h0c, 32'h7);
    toggles(80, n);
    chk(32'(n inside {[9:11]}), 32'h1);
    chk(32'(irqReq.per), 32'h1);
    busClkOn <= 1'b0;
    wt(2);
    toggles(40, n);
    chk(32'(n), 32'h0);
    // auto rc source after a legal reconfiguration
    // disable, rewrite, enable
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h3);
    rd(8'h10, 32'h3);
    wr(8'h0c, 32'h5);
    toggles(300, n);
    chk(32'(n inside {[4:5]}), 32'h1);
    wr(8'h0c, 32'h1);
    chk(32'(pin), 32'h0);
    endSim();
  end
endmodule
bind cpei_event_irq cpei_event_irq_asserts u_chk (.clk_sys, .reset_n, .wbReq, .wbAck,
  .pllLock, .lowSupplyDet, .overTempDet, .irqReq, .crystalOscGood);
